// ### rtl/rsi_defines.vh
// constants for the reset-source register initialisation block
`ifndef RSI_DEFINES_VH
`define RSI_DEFINES_VH
// ----------------------------------------------------------------------------
// reset source index (one bit each in the source vector)
// ----------------------------------------------------------------------------
`define RSI_SRC_W 15
`define RSI_SRC_PIN 0
`define RSI_SRC_POR 1
`define RSI_SRC_VM0 2
`define RSI_SRC_IWDG 3
`define RSI_SRC_WDG 4
`define RSI_SRC_LOCKUP 5
`define RSI_SRC_VM1 6
`define RSI_SRC_VM2 7
`define RSI_SRC_SW 8
`define RSI_SRC_BUSERR 9
`define RSI_SRC_MEMERR 10
`define RSI_SRC_DS1 11
`define RSI_SRC_DS2 12
`define RSI_SRC_DS3 13
`define RSI_SRC_VBPOR 14
// ----------------------------------------------------------------------------
// per-group source masks
// ----------------------------------------------------------------------------
`define RSI_M_HOSCFRQ 15'h3806
`define RSI_M_VMCFG 15'h001F
`define RSI_M_VMSTAT 15'h381F
`define RSI_M_BATTPOR 15'h4000
`define RSI_M_MOSC 15'h07FF
`define RSI_M_BBEN 15'h0002
`define RSI_M_TAMPER 15'h0000
`define RSI_M_IWDG 15'h3780
`define RSI_M_PINS 15'h3FFF
`define RSI_M_LOCO 15'h3006
// ----------------------------------------------------------------------------
// bit positions in the group strobe vector
// ----------------------------------------------------------------------------
`define RSI_G_HOSC 0
`define RSI_G_VMCFG 1
`define RSI_G_VMSTAT 2
`define RSI_G_BATTPOR 3
`define RSI_G_MOSC 4
`define RSI_G_BBEN 5
`define RSI_G_TAMPER 6
`define RSI_G_IWDG 7
`define RSI_G_PINS 8
`define RSI_G_LOCO 9
// ----------------------------------------------------------------------------
// field widths and reset values
// ----------------------------------------------------------------------------
`define RSI_REG_W 8
`define RSI_REG_RST 8'h00
`define RSI_FRQ_16M 3'h0
`define RSI_FRQ_18M 3'h1
`define RSI_FRQ_20M 3'h2
`define RSI_FRQ_32M 3'h4
`define RSI_FRQ_48M 3'h7
`define RSI_OPT_W 16
`define RSI_OPT_HOSCEN 8
`define RSI_OPT_FRQ_LO 9
`define RSI_OPT_FRQ_HI 11
`define RSI_OPT_ECC 12
`define RSI_PIN_W 16
`define RSI_PIN_RST 16'h0000
`define RSI_SYSCLK_SOURCE_SELECT_RST 3'h1
`endif

// ### rtl/rsi_reset_source_init.v
// reset-source dependent initialisation of clock and system control state
//
// Overview of operation
// RULE1: frequency register reinitialised on power-on, monitor 0 and deep standby.
// RULE2: monitor 1/2 control, compare, filter reinit on pin, POR, VM0, watchdogs.
// RULE3: monitor second control and status also reinit on deep standby 1-3.
// RULE4: sub-oscillator, switch control 2, backup regs only on battery POR.
// RULE5: switch control 1 and main oscillator mode: all but deep standby, battery POR.
// RULE6: backup enable register reinitialised only on power-on reset.
// RULE7: battery input capture and tamper registers never reinitialised here.
// RULE8: independent watchdog regs reinit on VM2, sw, bus, mem, deep standby 2/3.
// RULE9: pins except sub-clock crystal go default on all but battery POR.
// RULE10: option oscillator enable bit low starts the fast oscillator after reset.
// RULE11: system clock source changes only by software write of select field.
// RULE12: option frequency code copied into frequency field after each RULE1 reset.
// RULE13: secure and non-secure option words kept; selection picks applied one.
// RULE14: memory ECC enable follows the initial ECC option bit.
// RULE15: after ECC option goes 1 to 0 a power-on reset must follow.
// RULE16: frequency codes 000,001,010,100,111 legal; others refused.
// RULE17: frequency writes must not happen while the oscillator runs.
// RULE18: each source decodes into per-group strobes; others keep contents.
`timescale 1ns/1ps
`default_nettype none
`include "rsi_defines.vh"
module rsi_reset_source_init (
   input wire clk,
   input wire arst_n,
   // one-cycle pulse: a reset of the kind(s) in rstSource just ended
   input wire rstEvent,
   input wire [`RSI_SRC_W-1:0] rstSource,
   // option words and selection
   input wire [`RSI_OPT_W-1:0] optWord1Nonsecure,
   input wire [`RSI_OPT_W-1:0] optWord1Secure,
   input wire optWord1Select,
   // software write port (one-cycle strobes)
   input wire hoscFreqWr,
   input wire [2:0] hoscFreqWrData,
   input wire hoscStopWr,
   input wire hoscStopWrData,
   input wire sysclkSelWr,
   input wire [2:0] sysclkSelWrData,
   input wire [3:0] grpWr,
   input wire [`RSI_REG_W-1:0] grpWrData,
   input wire [`RSI_PIN_W-1:0] pinWrData,
   input wire pinWr,
   // state
   output reg [2:0] hoscFreqField,
   output reg hoscStopBit,
   output reg [2:0] sysclkSourceSelect,
   output reg eccEnable,
   output reg [`RSI_REG_W-1:0] vmonCfg,
   output reg [`RSI_REG_W-1:0] vmonStat,
   output reg [`RSI_REG_W-1:0] battCtl,
   output reg [`RSI_REG_W-1:0] wdogCfg,
   output reg [`RSI_PIN_W-1:0] pinState,
   output reg [9:0] initStrobe,
   output reg freqWrRefused
);

   // -------------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------------
   function hit;
      input [`RSI_SRC_W-1:0] src;
      input [`RSI_SRC_W-1:0] mask;
      begin
         hit = |(src & mask);
      end
   endfunction

   function legalFreq;
      input [2:0] code;
      begin
         legalFreq = (code == `RSI_FRQ_16M) || (code == `RSI_FRQ_18M) ||
                     (code == `RSI_FRQ_20M) || (code == `RSI_FRQ_32M) ||
                     (code == `RSI_FRQ_48M);
      end
   endfunction

   // -------------------------------------------------------------------------
   // applied option word
   // -------------------------------------------------------------------------
   wire [`RSI_OPT_W-1:0] optApplied;
   assign optApplied = optWord1Select ? optWord1Secure :
                       optWord1Nonsecure; // [RULE13]
   wire optHoscStartEnN = optApplied[`RSI_OPT_HOSCEN];
   wire [2:0] optHoscFreqCode = optApplied[`RSI_OPT_FRQ_HI:`RSI_OPT_FRQ_LO];

   // -------------------------------------------------------------------------
   // per-group strobes
   // -------------------------------------------------------------------------
   wire sHosc = rstEvent & hit(rstSource, `RSI_M_HOSCFRQ); // [RULE1]
   wire sVmCfg = rstEvent & hit(rstSource, `RSI_M_VMCFG); // [RULE2]
   wire sVmStat = rstEvent & hit(rstSource, `RSI_M_VMSTAT); // [RULE3]
   wire sBattPor = rstEvent & hit(rstSource, `RSI_M_BATTPOR); // [RULE4]
   wire sMosc = rstEvent & hit(rstSource, `RSI_M_MOSC); // [RULE5]
   wire sBben = rstEvent & hit(rstSource, `RSI_M_BBEN); // [RULE6]
   wire sTamper = rstEvent & hit(rstSource, `RSI_M_TAMPER); // [RULE7]
   wire sIwdg = rstEvent & hit(rstSource, `RSI_M_IWDG); // [RULE8]
   wire sPins = rstEvent & hit(rstSource, `RSI_M_PINS); // [RULE9]
   wire sLoco = rstEvent & hit(rstSource, `RSI_M_LOCO);

   // the tamper bit stays in the vector although its mask is empty, so the
   // layout seen by the groups outside does not shift if that ever changes
   reg [9:0] strobeD;

   always @*
   begin
      strobeD = 10'h000;
      strobeD[`RSI_G_HOSC] = sHosc;
      strobeD[`RSI_G_VMCFG] = sVmCfg;
      strobeD[`RSI_G_VMSTAT] = sVmStat;
      strobeD[`RSI_G_BATTPOR] = sBattPor;
      strobeD[`RSI_G_MOSC] = sMosc;
      strobeD[`RSI_G_BBEN] = sBben;
      strobeD[`RSI_G_TAMPER] = sTamper;
      strobeD[`RSI_G_IWDG] = sIwdg;
      strobeD[`RSI_G_PINS] = sPins;
      strobeD[`RSI_G_LOCO] = sLoco;
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         initStrobe <= 10'h000;
      end
      else
      begin
         initStrobe <= strobeD; // [RULE18]
      end
   end

   // -------------------------------------------------------------------------
   // oscillator frequency, stop bit and clock select
   // -------------------------------------------------------------------------
   // frequency writes while running or with a reserved code are dropped
   wire freqWrOk = hoscFreqWr & hoscStopBit &
                   legalFreq(hoscFreqWrData); // [RULE16] [RULE17]

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         freqWrRefused <= 1'b0;
      end
      else
      begin
         freqWrRefused <= hoscFreqWr & ~freqWrOk; // [RULE16] [RULE17]
      end
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hoscFreqField <= `RSI_FRQ_16M;
      end
      else if (sHosc)
      begin
         // reset reload takes priority over a same-cycle write
         hoscFreqField <= optHoscFreqCode; // [RULE1] [RULE12]
      end
      else if (freqWrOk)
      begin
         hoscFreqField <= hoscFreqWrData; // [RULE12]
      end
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hoscStopBit <= 1'b1;
      end
      else if (rstEvent)
      begin
         // low option bit starts the oscillator before software runs
         hoscStopBit <= optHoscStartEnN; // [RULE10]
      end
      else if (hoscStopWr)
      begin
         hoscStopBit <= hoscStopWrData;
      end
   end

   // the start option never touches the clock source
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sysclkSourceSelect <= `RSI_SYSCLK_SOURCE_SELECT_RST;
      end
      else if (sysclkSelWr)
      begin
         sysclkSourceSelect <= sysclkSelWrData; // [RULE11]
      end
   end

   // sampled only at a reset end: a 1->0 change needs a POR anyway
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         eccEnable <= 1'b0;
      end
      else if (rstEvent)
      begin
         eccEnable <= optApplied[`RSI_OPT_ECC]; // [RULE14] [RULE15]
      end
   end

   // -------------------------------------------------------------------------
   // register groups: reload on their strobe, else software, else hold
   // -------------------------------------------------------------------------
   // a group written in the cycle of its own reload keeps the reload value
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         vmonCfg <= `RSI_REG_RST;
      end
      else if (sVmCfg)
      begin
         vmonCfg <= `RSI_REG_RST; // [RULE2]
      end
      else if (grpWr[0])
      begin
         vmonCfg <= grpWrData;
      end
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         vmonStat <= `RSI_REG_RST;
      end
      else if (sVmStat)
      begin
         vmonStat <= `RSI_REG_RST; // [RULE3]
      end
      else if (grpWr[1])
      begin
         vmonStat <= grpWrData;
      end
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         battCtl <= `RSI_REG_RST;
      end
      else if (sBattPor)
      begin
         battCtl <= `RSI_REG_RST; // [RULE4]
      end
      else if (grpWr[2])
      begin
         battCtl <= grpWrData;
      end
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wdogCfg <= `RSI_REG_RST;
      end
      else if (sIwdg)
      begin
         wdogCfg <= `RSI_REG_RST; // [RULE8]
      end
      else if (grpWr[3])
      begin
         wdogCfg <= grpWrData;
      end
   end

   // the crystal pins are not part of this vector: they keep their state
   // on every source, so they live outside this block
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pinState <= `RSI_PIN_RST;
      end
      else if (sPins)
      begin
         pinState <= `RSI_PIN_RST; // [RULE9]
      end
      else if (pinWr)
      begin
         pinState <= pinWrData;
      end
   end

endmodule
`default_nettype wire

// ### testbench/rsi_reset_source_init_properties.sv
// assertions on the ports of the reset-source initialisation block
`timescale 1ns/1ps
`default_nettype none
module rsi_reset_source_init_properties (
   input wire clk,
   input wire arst_n,
   input wire rstEvent,
   input wire [14:0] rstSource,
   input wire [15:0] optWord1Nonsecure,
   input wire [15:0] optWord1Secure,
   input wire optWord1Select,
   input wire hoscFreqWr,
   input wire hoscStopWr,
   input wire sysclkSelWr,
   input wire [2:0] hoscFreqField,
   input wire hoscStopBit,
   input wire [2:0] sysclkSourceSelect,
   input wire eccEnable,
   input wire [9:0] initStrobe,
   input wire freqWrRefused
);
   // option word the device is meant to apply
   wire [15:0] opt = optWord1Select ? optWord1Secure : optWord1Nonsecure;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   property strb(int b, logic [14:0] m);
      rstEvent |=> initStrobe[b] == |($past(rstSource) & m);
   endproperty
   chk_hosc_strobe: assert property (strb(0, 15'h3806))
      else $error("frequency group strobe wrong");
   chk_vmcfg_strobe: assert property (strb(1, 15'h001F))
      else $error("monitor config strobe wrong");
   chk_vmstat_strobe: assert property (strb(2, 15'h381F))
      else $error("monitor status strobe wrong");
   chk_batt_strobe: assert property (strb(3, 15'h4000))
      else $error("battery group strobe wrong");
   chk_iwdg_strobe: assert property (strb(7, 15'h3780))
      else $error("watchdog group strobe wrong");
   chk_strobe_idle: assert property (!rstEvent |=> initStrobe == 10'h000)
      else $error("strobe without reset event");
   chk_freq_copy: assert property (rstEvent && !hoscFreqWr &&
      |(rstSource & 15'h3806) |=> hoscFreqField == $past(opt[11:9]))
      else $error("frequency code not loaded");
   chk_osc_start: assert property (rstEvent && !hoscStopWr
      |=> hoscStopBit == $past(opt[8])) else $error("oscillator start wrong");
   chk_ecc_follow: assert property (rstEvent |=> eccEnable == $past(opt[12]))
      else $error("ecc enable wrong");
   chk_clk_hold: assert property (!sysclkSelWr |=> $stable(sysclkSourceSelect))
      else $error("clock select moved");
   chk_freq_refuse: assert property (hoscFreqWr && !hoscStopBit && !rstEvent
      |=> freqWrRefused && $stable(hoscFreqField)) else $error("write taken");
   cover property (rstEvent && rstSource[14]);
   cover property (freqWrRefused);
   cover property (hoscFreqWr && hoscStopBit);
endmodule
bind rsi_reset_source_init rsi_reset_source_init_properties u_props (.*);
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the reset-source initialisation block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
   begin \
      cmpCount++; \
      if ((a) !== (e)) \
      begin \
         fails++; \
         $display("CHECK FAILED %0t got %0h want %0h", $time, a, e); \
      end \
   end
module tb_top;
   logic clk = 1'b0, arst_n = 1'b0, rstEvent = 1'b0, optWord1Select = 1'b0;
   logic hoscFreqWr = 1'b0, hoscStopWr = 1'b0, hoscStopWrData = 1'b0;
   logic sysclkSelWr = 1'b0, pinWr = 1'b0;
   logic [2:0] hoscFreqWrData = 3'h0, sysclkSelWrData = 3'h0;
   logic [3:0] grpWr = 4'h0;
   logic [7:0] grpWrData = 8'hA5;
   logic [14:0] rstSource = 15'h0000;
   logic [15:0] optWord1Nonsecure = 16'h1800, optWord1Secure = 16'h0F00;
   logic [15:0] pinWrData = 16'hA55A;
   wire [2:0] hoscFreqField, sysclkSourceSelect;
   wire hoscStopBit, eccEnable, freqWrRefused;
   wire [7:0] vmonCfg, vmonStat, battCtl, wdogCfg;
   wire [15:0] pinState;
   wire [9:0] initStrobe;
   int fails = 0, cmpCount = 0, i;
   logic [9:0] e;
   // one row per reset source: the groups that source must reload
   localparam logic [9:0] ROWS [0:14] = '{10'h116, 10'h337, 10'h317,
      10'h116, 10'h116, 10'h110, 10'h110, 10'h190, 10'h190, 10'h190,
      10'h190, 10'h105, 10'h385, 10'h385, 10'h008};
   localparam logic [14:0] CODES = 15'h7888;
   rsi_reset_source_init u_rsi_reset_source_init (.*);
   always #25 clk = ~clk;
   task conclude;
      $display("comparisons %0d mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task rs;
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      `CHK({hoscFreqField, hoscStopBit, sysclkSourceSelect, eccEnable}, 8'h12)
      `CHK({vmonCfg, vmonStat, battCtl, wdogCfg, pinState}, 48'h0)
      `CHK({initStrobe, freqWrRefused}, 11'h000)
   endtask
   task go(input logic [14:0] s);
      @(posedge clk);
      rstEvent <= 1'b1;
      rstSource <= s;
      @(posedge clk);
      rstEvent <= 1'b0;
      @(negedge clk);
   endtask
   task fw(input logic [2:0] d);
      @(posedge clk);
      hoscFreqWr <= 1'b1;
      hoscFreqWrData <= d;
      @(posedge clk);
      hoscFreqWr <= 1'b0;
      @(negedge clk);
   endtask
   // stop bit set to 1 (stopped), every group and the pins get known non-reset values
   task pre;
      @(posedge clk);
      hoscStopWr <= 1'b1;
      hoscStopWrData <= 1'b1;
      grpWr <= 4'hF;
      pinWr <= 1'b1;
      @(posedge clk);
      hoscStopWr <= 1'b0;
      grpWr <= 4'h0;
      pinWr <= 1'b0;
      fw(3'h2);
   endtask
   initial
   begin
      repeat (3000) @(posedge clk);
      fails++;
      conclude;
   end
   initial
   begin
      rs;
      for (i = 0; i < 15; i++)
      begin
         pre;
         go(15'h0001 << i);
         e = ROWS[i];
         `CHK(initStrobe, e)
         `CHK(hoscFreqField, e[0] ? 3'h4 : 3'h2)
         `CHK(vmonCfg, e[1] ? 8'h00 : 8'hA5)
         `CHK(vmonStat, e[2] ? 8'h00 : 8'hA5)
         `CHK(battCtl, e[3] ? 8'h00 : 8'hA5)
         `CHK(wdogCfg, e[7] ? 8'h00 : 8'hA5)
         `CHK(pinState, e[8] ? 16'h0000 : 16'hA55A)
         `CHK({hoscStopBit, eccEnable}, 2'b01)
      end
      `CHK(sysclkSourceSelect, 3'h1)
      @(posedge clk);
      sysclkSelWr <= 1'b1;
      sysclkSelWrData <= 3'h3;
      @(posedge clk);
      sysclkSelWr <= 1'b0;
      @(negedge clk);
      `CHK(sysclkSourceSelect, 3'h3)
      // oscillator running: the write must bounce
      fw(3'h1);
      `CHK({freqWrRefused, hoscFreqField}, 4'hA)
      pre;
      fw(3'h3);
      `CHK({freqWrRefused, hoscFreqField}, 4'hA)
      for (i = 0; i < 5; i++)
      begin
         fw(CODES[3*i +: 3]);
         `CHK({freqWrRefused, hoscFreqField}, {1'b0, CODES[3*i +: 3]})
      end
      @(posedge clk);
      optWord1Select <= 1'b1;
      go(15'h0002);
      `CHK({hoscFreqField, hoscStopBit, eccEnable}, 5'h1E)
      rs;
      conclude;
   end
endmodule
`default_nettype wire
